// ===== verilog/serial_flash_cmd.sv
// Serial flash command handler: configure register, busy stream, status write, single-bit reads
module serial_flash_cmd
#(
	parameter int unsigned WRITE_CYCLES = flash_cmd_pkg::REG_WRITE_CYCLES
)
(
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire flash_cmd_pkg::spi_pins_t pins,
	input  wire logic                     ext_busy,
	input  wire logic [7:0]               mem_rdata,
	output logic                          so_out,
	output logic                          so_oe_n,
	output logic [flash_cmd_pkg::ADDR_W-1:0] mem_addr,
	output logic [15:0]                   status_word,
	output logic [7:0]                    config_word,
	output logic [8:0]                    prog_wrap_mask,
	output logic                          erase_dual_page,
	output logic                          busy_flag,
	output logic                          write_enable_latch
);
	import flash_cmd_pkg::*;

	spi_pins_t          pin_s;
	spi_pins_t          pin_p;
	phase_t             phase_reg;
	logic [5:0]         cnt_reg;
	logic [23:0]        sh_reg;
	logic [7:0]         opcode_reg;
	logic [6:0]         out_sh_reg;
	logic [2:0]         obit_reg;
	logic [15:0]        sr_reg;
	logic               dp_reg;
	logic               wel_reg;
	logic               timer_busy;
	logic               timer_done;
	logic               busy;
	logic               sclk_rise;
	logic               sclk_fall;
	logic               cs_rise;
	logic               frame;
	logic               hw_prot;
	logic               wr_stat_ok;
	logic               wr_cfg_ok;
	logic               start_wr;
	logic [7:0]         opc_next;
	logic [15:0]        sr_data;
	logic [7:0]         out_byte;

	pin_sync u_sync
	(
		.clk    (clk),
		.resetn (resetn),
		.d      (pins),
		.q      (pin_s),
		.q_prev (pin_p)
	);

	reg_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer
	(
		.clk    (clk),
		.resetn (resetn),
		.start  (start_wr),
		.busy   (timer_busy),
		.done   (timer_done)
	);

	assign busy = timer_busy | ext_busy;
	assign frame = !pin_s.cs_n;
	assign sclk_rise = frame && pin_s.sclk && !pin_p.sclk;
	assign sclk_fall = frame && !pin_s.sclk && pin_p.sclk;
	assign cs_rise = pin_s.cs_n && !pin_p.cs_n;
	assign opc_next = {sh_reg[6:0], pin_s.si};
	// Locked when upper protect set, or lower protect set with write-protect low
	assign hw_prot = sr_reg[SR_UPPER_STATUS_PROTECT_BIT] | (sr_reg[SR_LOWER_STATUS_PROTECT_BIT] & !pin_s.wp_n);
	assign wr_stat_ok = cs_rise && opcode_reg == OP_WRSTAT && phase_reg == PH_WDATA && wel_reg && !busy
		&& !hw_prot && (cnt_reg == CNT_WR8 || cnt_reg == CNT_WR16);
	assign wr_cfg_ok = cs_rise && opcode_reg == OP_WRCFG && phase_reg == PH_WDATA && wel_reg && !busy
		&& cnt_reg == CNT_WR8;
	assign start_wr = wr_stat_ok | wr_cfg_ok;
	assign out_byte = (opcode_reg == OP_RDCFG) ? {dp_reg, 7'h00} : mem_rdata;

	// New status value; low byte first, high byte second
	always_comb
	begin
		if (cnt_reg == CNT_WR16)
			sr_data = {sh_reg[7:0], sh_reg[15:8]};
		else
			sr_data = {sr_reg[15:8] & ~SR_ONE_BYTE_CLR[15:8], sh_reg[7:0]};
	end

	// Bit counter and input shift register, sampled on SCLK rising edges
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_reg <= '0;
			sh_reg <= '0;
		end
		else if (!frame)
			cnt_reg <= '0;
		else if (sclk_rise)
		begin
			sh_reg <= {sh_reg[22:0], pin_s.si};
			if (cnt_reg != CNT_MAX)
				cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Command phase sequencing
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase_reg <= PH_OPCODE;
			opcode_reg <= '0;
		end
		else if (!frame)
			phase_reg <= PH_OPCODE;
		else if (sclk_rise)
		begin
			unique case (phase_reg)
				PH_OPCODE:
					if (cnt_reg == CNT_OPC_LAST)
					begin
						opcode_reg <= opc_next;
						if (opc_next == OP_READ)
							phase_reg <= PH_ADDR;
						else if (opc_next == OP_FAST)
							phase_reg <= busy ? PH_IGNORE : PH_ADDR;
						else if (opc_next == OP_RDCFG)
							phase_reg <= PH_OUT;
						else if (opc_next == OP_STREAM)
							phase_reg <= PH_STREAM;
						else if (opc_next == OP_WRSTAT || opc_next == OP_WRCFG)
							phase_reg <= PH_WDATA;
						else
							phase_reg <= PH_IGNORE;
					end
				PH_ADDR:
					if (cnt_reg == CNT_ADDR_LAST)
						phase_reg <= (opcode_reg == OP_FAST) ? PH_DUMMY : PH_OUT;
				PH_DUMMY:
					if (cnt_reg == CNT_DUMMY_LAST)
						phase_reg <= PH_OUT;
				PH_OUT, PH_STREAM, PH_WDATA, PH_IGNORE:
					phase_reg <= phase_reg;
			endcase
		end
	end

	// Read address: loaded after the third address byte, advanced per byte output
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			mem_addr <= '0;
		else if (sclk_rise && phase_reg == PH_ADDR && cnt_reg == CNT_ADDR_LAST)
			mem_addr <= {sh_reg[22:0], pin_s.si};
		else if (sclk_fall && phase_reg == PH_OUT && obit_reg == 3'h0 && opcode_reg != OP_RDCFG)
			mem_addr <= mem_addr + 1'b1;
	end

	// Serial output: bytes on SCLK falling edges, busy flag streamed every clock
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			so_out <= 1'b0;
			so_oe_n <= 1'b1;
			out_sh_reg <= '0;
			obit_reg <= '0;
		end
		else if (!frame)
		begin
			so_oe_n <= 1'b1;
			obit_reg <= '0;
		end
		else if (phase_reg == PH_STREAM)
		begin
			so_out <= busy;
			so_oe_n <= 1'b0;
		end
		else if (sclk_fall && phase_reg == PH_OUT)
		begin
			so_oe_n <= 1'b0;
			obit_reg <= obit_reg + 1'b1;
			if (obit_reg == 3'h0)
			begin
				so_out <= out_byte[7];
				out_sh_reg <= out_byte[6:0];
			end
			else
			begin
				so_out <= out_sh_reg[6];
				out_sh_reg <= {out_sh_reg[5:0], 1'b0};
			end
		end
	end

	// Write enable latch: set wins over completion clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wel_reg <= 1'b0;
		else if (cs_rise && opcode_reg == OP_WRITE_ENABLE_CMD && cnt_reg == CNT_OPC_LAST + 6'h01)
			wel_reg <= 1'b1;
		else if (timer_done || (cs_rise && opcode_reg == OP_WRDIS))
			wel_reg <= 1'b0;
	end

	// Status and configure register contents
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sr_reg <= SR_RESET;
			dp_reg <= CFG_RESET[CFG_DP];
		end
		else
		begin
			if (wr_stat_ok)
				sr_reg <= (sr_reg & SR_KEEP_MASK) | (sr_data & ~SR_KEEP_MASK);
			if (wr_cfg_ok)
				dp_reg <= sh_reg[CFG_DP];
		end
	end

	// Registered views of the block state
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_word <= SR_RESET;
			config_word <= CFG_RESET;
			prog_wrap_mask <= WRAP_MASK_256;
			erase_dual_page <= 1'b0;
			busy_flag <= 1'b0;
			write_enable_latch <= 1'b0;
		end
		else
		begin
			status_word <= {sr_reg[15:2], wel_reg, busy};
			config_word <= {dp_reg, 7'h00};
			prog_wrap_mask <= dp_reg ? WRAP_MASK_512 : WRAP_MASK_256;
			erase_dual_page <= dp_reg;
			busy_flag <= busy;
			write_enable_latch <= wel_reg;
		end
	end

	sequence s_write_start;
		start_wr && !timer_busy;
	endsequence
	sequence s_busy_held;
		busy_flag [*8];
	endsequence

	property p_wrap_mask;
		@(posedge clk) disable iff (!resetn) ##1 prog_wrap_mask == (($past(dp_reg)) ? WRAP_MASK_512 : WRAP_MASK_256);
	endproperty
	a_wrap_mask: assert property (p_wrap_mask) else $error("wrap mask disagrees with dual page");

	property p_stream_so;
		@(posedge clk) disable iff (!resetn) (frame && phase_reg == PH_STREAM) |=> (so_out == $past(busy) && !so_oe_n);
	endproperty
	a_stream_so: assert property (p_stream_so) else $error("busy stream not on SO");

	property p_release;
		@(posedge clk) disable iff (!resetn) cs_rise |=> so_oe_n;
	endproperty
	a_release: assert property (p_release) else $error("SO not released at select rise");

	property p_needs_wel;
		@(posedge clk) disable iff (!resetn) start_wr |-> (write_enable_latch && wel_reg && !busy);
	endproperty
	a_needs_wel: assert property (p_needs_wel) else $error("write started without latch");

	property p_keep_bits;
		@(posedge clk) disable iff (!resetn) wr_stat_ok |=> (sr_reg & SR_KEEP_MASK) == ($past(sr_reg) & SR_KEEP_MASK);
	endproperty
	a_keep_bits: assert property (p_keep_bits) else $error("kept status bits changed");

	property p_busy_cycle;
		@(posedge clk) disable iff (!resetn) s_write_start |=> ##2 s_busy_held;
	endproperty
	a_busy_cycle: assert property (p_busy_cycle) else $error("busy not held after write start");

	property p_hw_prot;
		@(posedge clk) disable iff (!resetn) wr_stat_ok |-> !(sr_reg[SR_LOWER_STATUS_PROTECT_BIT] && !sr_reg[SR_UPPER_STATUS_PROTECT_BIT] && !pin_s.wp_n);
	endproperty
	a_hw_prot: assert property (p_hw_prot) else $error("status write in protected mode");

	property p_fast_reject;
		@(posedge clk) disable iff (!resetn)
			(sclk_rise && phase_reg == PH_OPCODE && cnt_reg == CNT_OPC_LAST && opc_next == OP_FAST && busy)
			|=> phase_reg == PH_IGNORE;
	endproperty
	a_fast_reject: assert property (p_fast_reject) else $error("fast read accepted while busy");

	property p_addr_inc;
		@(posedge clk) disable iff (!resetn)
			(sclk_fall && phase_reg == PH_OUT && obit_reg == 3'h0 && opcode_reg == OP_READ)
			|=> mem_addr == $past(mem_addr) + 1'b1;
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("read address did not advance");
endmodule

// ===== verilog/flash_cmd_pkg.sv
// Constants, types and opcodes for the serial flash register and read command block
package flash_cmd_pkg;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_RDCFG = 8'h15;
	localparam logic [7:0] OP_STREAM = 8'h25;
	localparam logic [7:0] OP_WRSTAT = 8'h01;
	localparam logic [7:0] OP_WRCFG = 8'h31;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_WRDIS = 8'h04;
	localparam int SR_LOWER_STATUS_PROTECT_BIT = 7;
	localparam int SR_UPPER_STATUS_PROTECT_BIT = 8;
	localparam int SR_QE = 9;
	localparam int SR_CMP = 14;
	localparam int CFG_DP = 7;
	localparam logic [15:0] SR_KEEP_MASK = 16'h8403;
	localparam logic [15:0] SR_ONE_BYTE_CLR = 16'h4300;
	localparam logic [15:0] SR_RESET = 16'h0000;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [5:0] CNT_OPC_LAST = 6'h07;
	localparam logic [5:0] CNT_ADDR_LAST = 6'h1F;
	localparam logic [5:0] CNT_DUMMY_LAST = 6'h27;
	localparam logic [5:0] CNT_WR8 = 6'h10;
	localparam logic [5:0] CNT_WR16 = 6'h18;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	localparam logic [8:0] WRAP_MASK_256 = 9'h0FF;
	localparam logic [8:0] WRAP_MASK_512 = 9'h1FF;
	localparam int ADDR_W = 24;
	localparam int CLK_PERIOD_NS = 50;
	localparam int REG_WRITE_TIME_NS = 5000000;
	localparam int REG_WRITE_CYCLES = REG_WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 20;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic si;
		logic wp_n;
	} spi_pins_t;
	typedef enum logic [6:0] {
		PH_OPCODE = 7'b0000001,
		PH_ADDR   = 7'b0000010,
		PH_DUMMY  = 7'b0000100,
		PH_OUT    = 7'b0001000,
		PH_STREAM = 7'b0010000,
		PH_WDATA  = 7'b0100000,
		PH_IGNORE = 7'b1000000
	} phase_t;
endpackage

// ===== verilog/pin_sync.sv
// Two-stage synchroniser for the serial pins with a third stage for edge finding
module pin_sync
(
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire flash_cmd_pkg::spi_pins_t d,
	output flash_cmd_pkg::spi_pins_t     q,
	output flash_cmd_pkg::spi_pins_t     q_prev
);
	import flash_cmd_pkg::*;
	spi_pins_t meta_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, wp_n: 1'b1};
			q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, wp_n: 1'b1};
			q_prev <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, wp_n: 1'b1};
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
			q_prev <= q;
		end
	end
endmodule

// ===== verilog/reg_write_timer.sv
// Self-timed register write cycle counter
module reg_write_timer
#(
	parameter int unsigned CYCLES = flash_cmd_pkg::REG_WRITE_CYCLES
)
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	import flash_cmd_pkg::*;
	logic [TIMER_W-1:0] cnt_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				busy <= 1'b1;
				cnt_reg <= '0;
			end
			else if (busy)
			begin
				if (cnt_reg == TIMER_W'(CYCLES - 1))
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule

// ===== test/spi_host.sv
// Host serial controller model driving the flash pins in mode 0
module spi_host
(
	input  wire logic                clk,
	input  wire logic                wp_n,
	input  wire logic                so_line,
	output flash_cmd_pkg::spi_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ns;
	import flash_cmd_pkg::*;

	initial pins = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, wp_n: 1'b1};

	always @(negedge clk)
		pins.wp_n <= wp_n;

	// One frame: opcode then n bits, select raised at any count
	task automatic frame(input logic [7:0] op, input logic [55:0] tx, input int n, input int hold,
		output logic [55:0] rx);
		logic [63:0] sh;
		sh = {op, tx << (56 - n)};
		rx = '0;
		pins.cs_n <= 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 0; i < n + 8; i++)
		begin
			pins.sclk <= 1'b0;
			pins.si <= sh[63 - i];
			repeat (4) @(negedge clk);
			pins.sclk <= 1'b1;
			rx = {rx[54:0], so_line};
			repeat (4) @(negedge clk);
		end
		pins.sclk <= 1'b0;
		repeat (4 + hold) @(negedge clk);
		pins.cs_n <= 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ===== test/tb_top.sv
// Self-checking testbench for the serial flash command block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_cmd_pkg::*;
	localparam int WC = 20;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic              ext_busy = 1'b0;
	logic              wp_n = 1'b1;
	logic [7:0]        mem_rdata;
	logic              so_out;
	logic              so_oe_n;
	logic              erase_dual_page;
	logic              busy_flag;
	logic              write_enable_latch;
	logic [ADDR_W-1:0] mem_addr;
	logic [15:0]       status_word;
	logic [7:0]        config_word;
	logic [8:0]        prog_wrap_mask;
	spi_pins_t         pins;
	logic              so_last = 1'b0;
	logic              so_line;
	logic              oe_seen = 1'b0;
	logic [55:0]       rx;
	logic [15:0]       s;
	logic [15:0]       old;
	logic [23:0]       a;
	int                n_mismatch = 0;
	int                total_checks = 0;
	int                nb[5] = '{16, 8, 12, 16, 16};
	bit                wpv[5] = '{1, 1, 1, 0, 1};
	bit                acc[5] = '{1, 1, 0, 0, 1};

	always #25 clk = ~clk;

	function automatic logic [7:0] mem_val(input logic [23:0] ad);
		return ad[7:0] ^ ad[23:16] ^ 8'h5A;
	endfunction

	function automatic logic [15:0] exp_sr(input logic [15:0] o, input logic [15:0] d, input bit one);
		logic [15:0] e;
		e = one ? {o[15:8] & ~SR_ONE_BYTE_CLR[15:8], d[7:0]} : d;
		return (o & SR_KEEP_MASK) | (e & ~SR_KEEP_MASK);
	endfunction

	// Array model and released output line
	assign mem_rdata = mem_val(mem_addr);
	assign so_line = so_oe_n ? ~so_last : so_out;
	always @(posedge clk)
	begin
		if (!so_oe_n)
			so_last <= so_out;
		if (!so_oe_n)
			oe_seen <= 1'b1;
	end

	serial_flash_cmd #(.WRITE_CYCLES(WC)) dut (.clk(clk), .resetn(resetn), .pins(pins), .ext_busy(ext_busy),
		.mem_rdata(mem_rdata), .so_out(so_out), .so_oe_n(so_oe_n), .mem_addr(mem_addr),
		.status_word(status_word), .config_word(config_word), .prog_wrap_mask(prog_wrap_mask),
		.erase_dual_page(erase_dual_page), .busy_flag(busy_flag), .write_enable_latch(write_enable_latch));

	spi_host host (.clk(clk), .wp_n(wp_n), .so_line(so_line), .pins(pins));

	task automatic cmd(input logic [7:0] op, input logic [55:0] tx, input int n);
		host.frame(op, tx, n, 0, rx);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 200 && busy_flag !== 1'b0; i++)
			@(negedge clk);
		repeat (2) @(negedge clk);
		`CHK("idle", 1'b0, busy_flag)
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("Error watchdog expired");
		results();
	end

	initial
	begin
		s = 16'($urandom(70040));
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		`CHK("cfg_rst", 8'h00, config_word)
		`CHK("wrap_rst", WRAP_MASK_256, prog_wrap_mask)
		`CHK("oe_rst", 1'b1, so_oe_n)
		// Config writes: no latch, short count, then accepted
		cmd(OP_WRCFG, 56'h80, 8);
		`CHK("cfg_nolatch", 1'b0, busy_flag)
		cmd(OP_WRITE_ENABLE_CMD, 56'h0, 0);
		`CHK("wel_set", 1'b1, write_enable_latch)
		cmd(OP_WRCFG, 56'h0, 7);
		`CHK("cfg_short", 1'b0, busy_flag)
		cmd(OP_WRCFG, 56'h80 | 56'($urandom_range(127)), 8);
		`CHK("busy_cfg", 1'b1, busy_flag)
		wait_idle();
		`CHK("wel_cfg", 1'b0, write_enable_latch)
		`CHK("cfg_dp", 8'h80, config_word)
		`CHK("wrap_dp", WRAP_MASK_512, prog_wrap_mask)
		`CHK("erase_dp", 1'b1, erase_dual_page)
		// Reads while an outside cycle runs
		ext_busy = 1'b1;
		cmd(OP_RDCFG, 56'h0, 8);
		`CHK("rdcfg", 8'h80, rx[7:0])
		oe_seen = 1'b0;
		cmd(OP_FAST, 56'h0, 48);
		`CHK("fast_busy", 1'b0, oe_seen)
		// Busy stream with random bits after the opcode
		fork
			host.frame(OP_STREAM, 56'($urandom_range(255)), 8, 30, rx);
			begin
				repeat (142) @(negedge clk);
				`CHK("stream_hi", 1'b1, so_out)
				ext_busy = 1'b0;
				repeat (8) @(negedge clk);
				`CHK("stream_lo", 1'b0, so_out)
			end
		join
		`CHK("stream_rel", 1'b1, so_oe_n)
		// Status writes: lengths, protection and refused cases
		cmd(OP_WRSTAT, 56'h0, 16);
		`CHK("sr_nolatch", 1'b0, busy_flag)
		for (int i = 0; i < 5; i++)
		begin
			wp_n = wpv[i];
			cmd(OP_WRITE_ENABLE_CMD, 56'h0, 0);
			old = status_word;
			s = (16'($urandom) & 16'hFE7F) | (i == 1 ? 16'h0080 : 16'h0000);
			cmd(OP_WRSTAT, 56'({s[7:0], s[15:8]} >> (16 - nb[i])), nb[i]);
			`CHK("sr_busy", acc[i], busy_flag)
			wait_idle();
			s = acc[i] ? exp_sr(old, s, nb[i] == 8) : old;
			`CHK("sr_val", s[15:2] & 14'h31FF, status_word[15:2] & 14'h31FF)
			`CHK("sr_wel", !acc[i], write_enable_latch)
		end
		// Array reads across the top address and at a random address, plain and fast
		for (int i = 0; i < 2; i++)
		begin
			a = i == 0 ? 24'hFFFFFF : 24'($urandom);
			cmd(OP_READ, 56'({a, 16'h0}), 40);
			`CHK("read", {mem_val(a), mem_val(a + 24'h1)}, rx[15:0])
			cmd(OP_FAST, 56'({a, 24'h0}), 48);
			`CHK("fast", {mem_val(a), mem_val(a + 24'h1)}, rx[15:0])
		end
		// Select raised four bits into the first data byte
		cmd(OP_READ, 56'({a, 4'h0}), 28);
		s = {8'h00, mem_val(a)};
		`CHK("read_part", s[7:4], rx[3:0])
		`CHK("read_end", 1'b1, so_oe_n)
		cmd(OP_RDCFG, 56'h0, 8);
		`CHK("rdcfg_after", 8'h80, rx[7:0])
		results();
	end
endmodule
